//--- hdl/xrp_params.svh
`ifndef XRP_PARAMS_SVH
`define XRP_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define XRP_NUM_CH        4
`define XRP_NUM_SYNTH     2
`define XRP_NUM_ARST      14

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define XRP_OFS_CTRL      12'h000
`define XRP_OFS_STATUS    12'h004
`define XRP_OFS_IRQ_STAT  12'h008
`define XRP_OFS_IRQ_MASK  12'h00C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define XRP_CTRL_TXD_LSB  0
`define XRP_CTRL_RXD_LSB  4
`define XRP_CTRL_RXA_LSB  8
`define XRP_CTRL_USE_LSB  12
`define XRP_CTRL_CAL_BIT  16
`define XRP_CTRL_RESET    17'h03000

// ----------------------------------------------------------------
// Status and interrupt fields
// ----------------------------------------------------------------
`define XRP_ST_TXLOCK_BIT 0
`define XRP_ST_RXLOCK_LSB 1
`define XRP_ST_FREQ_LSB   5
`define XRP_ST_BUSY_BIT   9
`define XRP_ST_BLKPD_BIT  10
`define XRP_IRQ_TXLOST    0
`define XRP_IRQ_RXLOST    1
`define XRP_IRQ_CALDONE   2
`define XRP_IRQ_MASK_RST  3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define XRP_CLK_MHZ       50
`define XRP_MIN_PULSE_CYC 2
`define XRP_OC_TIME_NS    2000
`define XRP_OC_CYC        ((`XRP_OC_TIME_NS * `XRP_CLK_MHZ) / 1000)

`endif

//--- hdl/xrp_pkg.sv
package xrp_pkg;
  typedef enum logic [1:0] {XRP_CAL_IDLE, XRP_CAL_FIRST, XRP_CAL_BUSY} xrp_cal_e;
  typedef logic [3:0]  xrp_ch_t;
  typedef logic [1:0]  xrp_syn_t;
  typedef logic [31:0] xrp_word_t;
endpackage : xrp_pkg

//--- hdl/xrp_sync.sv
module xrp_sync
(
  input  wire logic clk,
  input  wire logic arst,
  output logic      rst_out
);
  logic meta_q;
  logic hold_q;

  // Assertion is immediate; release passes two edges so it lands cleanly on the clock.
  always_ff @(posedge clk or posedge arst)
  begin
    if (arst)
    begin
      meta_q <= 1'b1;
      hold_q <= 1'b1;
    end
    else
    begin
      meta_q <= 1'b0;
      hold_q <= meta_q;
    end
  end

  assign rst_out = hold_q;
endmodule : xrp_sync

//--- hdl/xrp_ctrl.sv
`include "xrp_params.svh"
// What this block does
// - Every reset and power-down input except RESETN passes a two-flop synchronizer; release is aligned to REF_CLK.
// - Transmit digital reset clears transmit coding logic; held two cycles minimum.
// - Receive digital reset clears receive coding logic; held two cycles minimum.
// - Receive analog reset resets clock recovery, deserializer and signal detect.
// - While calibration busy, receive analog reset is ignored; analog parts stay on.
// - Receive analog reset forces both receive lock indications low, busy or not.
// - Two synthesizers, each power-down stops the clocks it supplies.
// - One synthesizer power-down port powers down whichever synthesizers are used.
// - Block power-down stops all sublayers and synthesizers, independent of resets.
// - The reference clock input buffer is never powered down.
// - Transmit lock is high only while the synthesizer is locked.
// - Receive lock is high while clock recovery is locked to reference.
// - Frequency lock is high in lock-to-data mode, low in lock-to-reference.
// - Busy stays low for the first calibration cycle, rises from the second.
module xrp_ctrl
(
  input  wire logic               REF_CLK,
  input  wire logic               RESETN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire xrp_pkg::xrp_word_t PWDATA,
  output xrp_pkg::xrp_word_t      PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire xrp_pkg::xrp_ch_t   TX_DIGITAL_RESET,
  input  wire xrp_pkg::xrp_ch_t   RX_DIGITAL_RESET,
  input  wire xrp_pkg::xrp_ch_t   RX_ANALOG_RESET,
  input  wire logic               SYNTH_POWERDOWN,
  input  wire logic               BLOCK_POWERDOWN,
  input  wire xrp_pkg::xrp_syn_t  SYNTH_LOCK_RAW,
  input  wire xrp_pkg::xrp_ch_t   CDR_LOCK_RAW,
  input  wire xrp_pkg::xrp_ch_t   CDR_LTD_RAW,
  output xrp_pkg::xrp_ch_t        TX_CS_RESET,
  output xrp_pkg::xrp_ch_t        RX_CS_RESET,
  output xrp_pkg::xrp_ch_t        RX_MAS_RESET,
  output xrp_pkg::xrp_ch_t        CH_POWERDOWN,
  output xrp_pkg::xrp_syn_t       SYNTH_CLK_EN,
  output logic                    REFCLK_BUF_EN,
  output logic                    TX_PLL_LOCKED,
  output xrp_pkg::xrp_ch_t        RX_PLL_LOCKED,
  output xrp_pkg::xrp_ch_t        RX_FREQ_LOCKED,
  output logic                    CAL_BUSY,
  output logic                    IRQ
);
  import xrp_pkg::*;

  // ----------------------------------------------------------------
  // Reset input synchronizers
  // ----------------------------------------------------------------
  logic [`XRP_NUM_ARST-1:0] arst_in;
  logic [`XRP_NUM_ARST-1:0] arst_sync;
  xrp_ch_t                  txd_s;
  xrp_ch_t                  rxd_s;
  xrp_ch_t                  rxa_s;
  logic                     synpd_s;
  logic                     blkpd_s;

  // The chip reset joins every input so nothing leaves reset half-initialised.
  assign arst_in = {BLOCK_POWERDOWN, SYNTH_POWERDOWN, RX_ANALOG_RESET,
                    RX_DIGITAL_RESET, TX_DIGITAL_RESET};

  genvar gi;
  generate
    for (gi = 0; gi < `XRP_NUM_ARST; gi++)
    begin : g_sync
      xrp_sync u_sync
      (
        .clk     (REF_CLK),
        .arst    (arst_in[gi] | ~RESETN),
        .rst_out (arst_sync[gi])
      );
    end
  endgenerate

  assign txd_s   = arst_sync[3:0];
  assign rxd_s   = arst_sync[7:4];
  assign rxa_s   = arst_sync[11:8];
  assign synpd_s = arst_sync[12];
  assign blkpd_s = arst_sync[13];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [16:0] ctrl_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  xrp_cal_e    cal_q;
  logic [7:0]  cal_cnt_q;
  logic        cal_init_q;
  logic        cal_done;
  logic        acc_done;
  logic        wr_ctrl;
  logic        cal_start;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `XRP_OFS_CTRL) || (a == `XRP_OFS_STATUS)
           || (a == `XRP_OFS_IRQ_STAT) || (a == `XRP_OFS_IRQ_MASK);
  endfunction : addr_ok

  assign acc_done  = PSEL && PENABLE && PREADY;
  assign wr_ctrl   = acc_done && PWRITE && (PADDR == `XRP_OFS_CTRL);
  assign cal_start = cal_init_q || (wr_ctrl && PWDATA[`XRP_CTRL_CAL_BIT]);

  // ----------------------------------------------------------------
  // Offset calibration sequencer
  // ----------------------------------------------------------------
  // A fixed-length model of the cancellation run; a start during a run is ignored.
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cal_q      <= XRP_CAL_IDLE;
      cal_cnt_q  <= 8'h00;
      cal_init_q <= 1'b1;
    end
    else
    begin
      cal_init_q <= 1'b0;
      case (cal_q)
        XRP_CAL_IDLE:
        begin
          if (cal_start)
          begin
            cal_q <= XRP_CAL_FIRST;
          end
        end
        XRP_CAL_FIRST:
        begin
          cal_q     <= XRP_CAL_BUSY;
          cal_cnt_q <= 8'(`XRP_OC_CYC - 1);
        end
        XRP_CAL_BUSY:
        begin
          if (cal_cnt_q == 8'h00)
          begin
            cal_q <= XRP_CAL_IDLE;
          end
          else
          begin
            cal_cnt_q <= cal_cnt_q - 8'h01;
          end
        end
        default:
        begin
          cal_q <= XRP_CAL_IDLE;
        end
      endcase
    end
  end

  assign cal_done = (cal_q == XRP_CAL_BUSY) && (cal_cnt_q == 8'h00);

  // ----------------------------------------------------------------
  // Reset and power-down outputs
  // ----------------------------------------------------------------
  xrp_syn_t syn_use;
  xrp_ch_t  rxa_req;
  logic     busy_now;

  assign syn_use  = ctrl_q[`XRP_CTRL_USE_LSB +: 2];
  assign busy_now = (cal_q == XRP_CAL_BUSY);
  assign rxa_req  = rxa_s | ctrl_q[`XRP_CTRL_RXA_LSB +: 4];

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TX_CS_RESET   <= 4'hF;
      RX_CS_RESET   <= 4'hF;
      RX_MAS_RESET  <= 4'hF;
      CH_POWERDOWN  <= 4'h0;
      SYNTH_CLK_EN  <= 2'h0;
      REFCLK_BUF_EN <= 1'b1;
    end
    else
    begin
      TX_CS_RESET   <= txd_s | ctrl_q[`XRP_CTRL_TXD_LSB +: 4];
      RX_CS_RESET   <= rxd_s | ctrl_q[`XRP_CTRL_RXD_LSB +: 4];
      RX_MAS_RESET  <= busy_now ? 4'h0 : rxa_req;
      CH_POWERDOWN  <= {4{blkpd_s}};
      SYNTH_CLK_EN  <= ~(({2{synpd_s}} & syn_use) | {2{blkpd_s}});
      REFCLK_BUF_EN <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Lock status outputs
  // ----------------------------------------------------------------
  logic    tx_lock_d;
  xrp_ch_t rx_lock_d;
  xrp_ch_t freq_d;

  assign tx_lock_d = |(SYNTH_LOCK_RAW & SYNTH_CLK_EN & syn_use);
  assign rx_lock_d = CDR_LOCK_RAW & ~rxa_req & {4{~blkpd_s}};
  assign freq_d    = CDR_LTD_RAW & CDR_LOCK_RAW & ~rxa_req & {4{~blkpd_s}};

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TX_PLL_LOCKED  <= 1'b0;
      RX_PLL_LOCKED  <= 4'h0;
      RX_FREQ_LOCKED <= 4'h0;
      CAL_BUSY       <= 1'b0;
    end
    else
    begin
      TX_PLL_LOCKED  <= tx_lock_d;
      RX_PLL_LOCKED  <= rx_lock_d;
      RX_FREQ_LOCKED <= freq_d;
      CAL_BUSY       <= (cal_q == XRP_CAL_FIRST) || (busy_now && !cal_done);
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  xrp_word_t status_w;
  xrp_word_t rd_mux;

  assign status_w = {21'h0, blkpd_s, CAL_BUSY, RX_FREQ_LOCKED, RX_PLL_LOCKED,
                     TX_PLL_LOCKED};

  always_comb
  begin
    rd_mux = 32'h0;
    case (PADDR)
      `XRP_OFS_CTRL:     rd_mux = {15'h0, 1'b0, ctrl_q[15:0]};
      `XRP_OFS_STATUS:   rd_mux = status_w;
      `XRP_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      `XRP_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
      default:           rd_mux = 32'h0;
    endcase
  end

  // Ready comes one cycle into the access phase so read data is registered.
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok(PADDR);
      if (PSEL && PENABLE && !PREADY && !PWRITE)
      begin
        PRDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_q     <= `XRP_CTRL_RESET;
      irq_mask_q <= `XRP_IRQ_MASK_RST;
    end
    else if (acc_done && PWRITE)
    begin
      if (PADDR == `XRP_OFS_CTRL)
      begin
        ctrl_q <= {1'b0, PWDATA[15:0]};
      end
      if (PADDR == `XRP_OFS_IRQ_MASK)
      begin
        irq_mask_q <= PWDATA[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] irq_set;
  logic [2:0] rd_clr;

  assign irq_set = {cal_done,
                    |(RX_PLL_LOCKED & ~rx_lock_d),
                    TX_PLL_LOCKED & !tx_lock_d};
  assign rd_clr  = {3{acc_done && !PWRITE && (PADDR == `XRP_OFS_IRQ_STAT)}} & PRDATA[2:0];

  // A read clears the bits it returned; an event in the same cycle survives.
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      irq_stat_q <= 3'h0;
      IRQ        <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~rd_clr) | irq_set;
      IRQ        <= |(((irq_stat_q & ~rd_clr) | irq_set) & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  chk_rx_lock_drop: assert property (
    (RX_ANALOG_RESET[0]) [*3] |-> !RX_PLL_LOCKED[0] && !RX_FREQ_LOCKED[0])
    else $error("receive lock high during analog reset");

  chk_busy_masks_rxa: assert property (
    (cal_q == XRP_CAL_BUSY) |=> RX_MAS_RESET == 4'h0)
    else $error("analog reset passed while calibrating");

  chk_busy_first_low: assert property (
    (cal_q == XRP_CAL_IDLE && cal_start) |=> !CAL_BUSY ##1 CAL_BUSY)
    else $error("busy timing wrong at calibration start");

  chk_busy_length: assert property (
    $rose(CAL_BUSY) |-> CAL_BUSY [*8])
    else $error("busy dropped too early");

  chk_txd_pulse: assert property (
    $rose(TX_DIGITAL_RESET[0]) |-> ##[1:2] TX_CS_RESET[0] [*2])
    else $error("transmit reset shorter than two cycles");

  chk_rxd_pulse: assert property (
    $rose(RX_DIGITAL_RESET[0]) |-> ##[1:2] RX_CS_RESET[0] [*2])
    else $error("receive reset shorter than two cycles");

  chk_blk_pd: assert property (
    BLOCK_POWERDOWN [*3] |-> CH_POWERDOWN == 4'hF && SYNTH_CLK_EN == 2'h0)
    else $error("block power-down not applied");

  chk_refclk_on: assert property (
    REFCLK_BUF_EN)
    else $error("reference clock buffer off");

  chk_tx_lock: assert property (
    TX_PLL_LOCKED |-> $past(|SYNTH_LOCK_RAW))
    else $error("transmit lock without synthesizer lock");

  chk_freq_mode: assert property (
    RX_FREQ_LOCKED[0] |-> $past(CDR_LTD_RAW[0]))
    else $error("frequency lock outside lock-to-data");

  chk_sync_release: assert property (
    $fell(TX_DIGITAL_RESET[1]) && RESETN && ctrl_q[1] == 1'b0
      |-> TX_CS_RESET[1] ##1 TX_CS_RESET[1])
    else $error("reset released too soon");

  cov_cal_run:   cover property ($fell(CAL_BUSY));
  cov_irq:       cover property ($rose(IRQ));
  cov_rxa_busy:  cover property (RX_ANALOG_RESET[0] && CAL_BUSY);
  cov_blk_pd:    cover property ($rose(CH_POWERDOWN[0]));
endmodule : xrp_ctrl

//--- tb/xrp_fabric_ctl.sv
module xrp_fabric_ctl
(
  input  wire logic             clk,
  input  wire logic             tx_locked,
  input  wire xrp_pkg::xrp_ch_t rx_locked,
  output xrp_pkg::xrp_ch_t      tx_rst,
  output xrp_pkg::xrp_ch_t      rx_rst,
  output xrp_pkg::xrp_ch_t      rxa_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  import xrp_pkg::*;

  // Digital resets start asserted, since clocks are not yet stable.
  initial
  begin
    tx_rst  = 4'hF;
    rx_rst  = 4'hF;
    rxa_rst = 4'h0;
  end

  task automatic set_rst(input int k, input xrp_ch_t m);
    @(posedge clk);
    case (k)
      0:       tx_rst  <= tx_rst | m;
      1:       rx_rst  <= rx_rst | m;
      default: rxa_rst <= rxa_rst | m;
    endcase
  endtask : set_rst

  // Every release waits two cycles, so no pulse is ever shorter.
  task automatic clr_rst(input int k, input xrp_ch_t m);
    repeat (2) @(posedge clk);
    case (k)
      0:       tx_rst  <= tx_rst & ~m;
      1:       rx_rst  <= rx_rst & ~m;
      default: rxa_rst <= rxa_rst & ~m;
    endcase
  endtask : clr_rst

  // The wait has no bound of its own; the bench watchdog ends a hang.
  task automatic release_digital;
    while (!(tx_locked === 1'b1 && rx_locked === 4'hF))
    begin
      @(posedge clk);
    end
    clr_rst(0, 4'hF);
    clr_rst(1, 4'hF);
  endtask : release_digital
endmodule : xrp_fabric_ctl

//--- tb/transceiver_reset_powerdown_ctrl_bench.sv
`include "xrp_params.svh"
module transceiver_reset_powerdown_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import xrp_pkg::*;

  typedef struct {int k; logic [31:0] e;} xrp_note_s;

  logic        REF_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  xrp_word_t   PWDATA, PRDATA;
  xrp_ch_t     TX_DIGITAL_RESET, RX_DIGITAL_RESET, RX_ANALOG_RESET;
  xrp_ch_t     CDR_LOCK_RAW, CDR_LTD_RAW, TX_CS_RESET, RX_CS_RESET;
  xrp_ch_t     RX_MAS_RESET, CH_POWERDOWN, RX_PLL_LOCKED, RX_FREQ_LOCKED;
  xrp_syn_t    SYNTH_LOCK_RAW, SYNTH_CLK_EN;
  logic        SYNTH_POWERDOWN, BLOCK_POWERDOWN, REFCLK_BUF_EN;
  logic        TX_PLL_LOCKED, CAL_BUSY, IRQ;
  logic [31:0] rd_v, busy_len;
  logic        err_v;
  xrp_note_s   q[$];
  int          errors, samples_checked, i;
  event        look;
  string       nm[16] = '{"tx_cs_reset", "rx_cs_reset", "rx_mas_reset", "ch_powerdown",
    "synth_clk_en", "refclk_buf_en", "tx_pll_locked", "rx_pll_locked", "rx_freq_locked",
    "cal_busy", "irq", "rdata", "pslverr", "busy_len", "rx_pll_locked0", "spare"};

  xrp_ctrl u_xrp_ctrl (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_DIGITAL_RESET(TX_DIGITAL_RESET),
    .RX_DIGITAL_RESET(RX_DIGITAL_RESET), .RX_ANALOG_RESET(RX_ANALOG_RESET),
    .SYNTH_POWERDOWN(SYNTH_POWERDOWN), .BLOCK_POWERDOWN(BLOCK_POWERDOWN),
    .SYNTH_LOCK_RAW(SYNTH_LOCK_RAW), .CDR_LOCK_RAW(CDR_LOCK_RAW), .CDR_LTD_RAW(CDR_LTD_RAW),
    .TX_CS_RESET(TX_CS_RESET), .RX_CS_RESET(RX_CS_RESET), .RX_MAS_RESET(RX_MAS_RESET),
    .CH_POWERDOWN(CH_POWERDOWN), .SYNTH_CLK_EN(SYNTH_CLK_EN), .REFCLK_BUF_EN(REFCLK_BUF_EN),
    .TX_PLL_LOCKED(TX_PLL_LOCKED), .RX_PLL_LOCKED(RX_PLL_LOCKED),
    .RX_FREQ_LOCKED(RX_FREQ_LOCKED), .CAL_BUSY(CAL_BUSY), .IRQ(IRQ));

  xrp_fabric_ctl u_xrp_fabric_ctl (.clk(REF_CLK), .tx_locked(TX_PLL_LOCKED),
    .rx_locked(RX_PLL_LOCKED), .tx_rst(TX_DIGITAL_RESET), .rx_rst(RX_DIGITAL_RESET),
    .rxa_rst(RX_ANALOG_RESET));

  initial
  begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  function automatic logic [31:0] probe(input int k);
    case (k)
      0:  return 32'(TX_CS_RESET);
      1:  return 32'(RX_CS_RESET);
      2:  return 32'(RX_MAS_RESET);
      3:  return 32'(CH_POWERDOWN);
      4:  return 32'(SYNTH_CLK_EN);
      5:  return 32'(REFCLK_BUF_EN);
      6:  return 32'(TX_PLL_LOCKED);
      7:  return 32'(RX_PLL_LOCKED);
      8:  return 32'(RX_FREQ_LOCKED);
      9:  return 32'(CAL_BUSY);
      10: return 32'(IRQ);
      12: return 32'(err_v);
      13: return busy_len;
      14: return 32'(RX_PLL_LOCKED[0]);
      default: return rd_v;
    endcase
  endfunction : probe

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, seen);
    end
  endtask : check

  // The monitor pops every note at each look, so notes never go stale.
  initial
  begin
    xrp_note_s n;
    forever
    begin
      @(look);
      while (q.size() > 0)
      begin
        n = q.pop_front();
        check(nm[n.k], probe(n.k), n.e);
      end
    end
  end

  task automatic exp(input int k, input logic [31:0] e);
    q.push_back('{k, e});
    ->look;
  endtask : exp

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : settle

  task automatic apb(input logic w, input logic [11:0] a, input xrp_word_t d);
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
    end
    while (PREADY !== 1'b1);
    rd_v    = PRDATA;
    err_v   = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask : apb

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial
  begin
    #200000;
    errors++;
    results();
  end

  initial
  begin
    void'($urandom(32'hC54B));
    {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {SYNTH_POWERDOWN, BLOCK_POWERDOWN} = 2'b00;
    SYNTH_LOCK_RAW = 2'b11;
    CDR_LOCK_RAW   = 4'hF;
    CDR_LTD_RAW    = 4'h0;
    settle(20);
    RESETN <= 1'b1;
    settle(1);
    exp(9, 0);
    fork
      begin
        i = 0;
        while (CAL_BUSY !== 1'b1 && i < 10)
        begin
          settle(1);
          i++;
        end
        busy_len = 0;
        while (CAL_BUSY === 1'b1 && busy_len < 300)
        begin
          busy_len++;
          settle(1);
        end
        exp(13, `XRP_OC_CYC);
      end
      begin
        settle(4);
        u_xrp_fabric_ctl.set_rst(2, 4'h1);
        settle(3);
        exp(2, 0);
        exp(14, 0);
        u_xrp_fabric_ctl.clr_rst(2, 4'h1);
      end
    join
    u_xrp_fabric_ctl.set_rst(2, 4'h2);
    settle(3);
    exp(2, 32'h2);
    u_xrp_fabric_ctl.clr_rst(2, 4'h2);
    settle(4);
    exp(2, 0);
    u_xrp_fabric_ctl.release_digital();
    settle(4);
    exp(0, 0);
    exp(1, 0);
    u_xrp_fabric_ctl.set_rst(0, 4'h5);
    u_xrp_fabric_ctl.set_rst(1, 4'hA);
    settle(3);
    exp(0, 32'h5);
    exp(1, 32'hA);
    u_xrp_fabric_ctl.clr_rst(0, 4'h5);
    u_xrp_fabric_ctl.clr_rst(1, 4'hA);
    settle(4);
    exp(6, 1);
    for (i = 0; i < 4; i++)
    begin
      CDR_LOCK_RAW <= 4'($urandom);
      CDR_LTD_RAW  <= 4'($urandom);
      settle(3);
      exp(7, 32'(CDR_LOCK_RAW));
      exp(8, 32'(CDR_LOCK_RAW & CDR_LTD_RAW));
    end
    apb(1'b0, `XRP_OFS_CTRL, 0);
    exp(11, 32'(`XRP_CTRL_RESET));
    exp(12, 0);
    apb(1'b0, 12'h010, 0);
    exp(11, 0);
    exp(12, 1);
    apb(1'b1, `XRP_OFS_IRQ_MASK, 32'h1);
    SYNTH_LOCK_RAW <= 2'b00;
    settle(4);
    exp(6, 0);
    exp(10, 1);
    apb(1'b0, `XRP_OFS_IRQ_STAT, 0);
    rd_v = rd_v & 32'h1;
    exp(11, 32'h1);
    settle(2);
    exp(10, 0);
    SYNTH_POWERDOWN <= 1'b1;
    settle(4);
    exp(4, 0);
    exp(5, 1);
    SYNTH_POWERDOWN <= 1'b0;
    settle(4);
    exp(4, 32'h3);
    BLOCK_POWERDOWN <= 1'b1;
    settle(4);
    exp(3, 32'hF);
    exp(4, 0);
    exp(5, 1);
    BLOCK_POWERDOWN <= 1'b0;
    settle(4);
    exp(3, 0);
    // Software start of calibration, a software transmit reset and one synthesizer in use.
    apb(1'b1, `XRP_OFS_CTRL, 32'h0001_1004);
    settle(2);
    exp(9, 1);
    exp(0, 32'h4);
    SYNTH_POWERDOWN <= 1'b1;
    settle(4);
    exp(4, 32'h2);
    apb(1'b0, `XRP_OFS_CTRL, 0);
    exp(11, 32'h1004);
    SYNTH_POWERDOWN <= 1'b0;
    results();
  end
endmodule : transceiver_reset_powerdown_ctrl_bench
